// ### hw/valve_ms_timer.sv
`default_nettype none

module valve_ms_timer #(
  parameter int LIMIT_MS = 100
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic tick,
  input wire logic clear,
  // result
  output logic expired
);

  typedef struct packed {
    logic [15:0] cnt;
    logic expired;
  } tmr_t;

  tmr_t st;
  tmr_t next_st;

  always_comb begin
    next_st = st;
    if (clear) begin
      next_st.cnt = 16'h0000;
      next_st.expired = 1'b0;
    end else if (tick && !st.expired) begin
      if (st.cnt == 16'(LIMIT_MS - 1)) begin
        next_st.expired = 1'b1;
      end else begin
        next_st.cnt = st.cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign expired = st.expired;

endmodule

`default_nettype wire

// ### hw/valve_slave_io.sv
// Summary of operation
// - report top on bit 3, bottom bit 2
// - output bit 0 drives pilot; bit 1 ignored
// - parameter bit 0: zero starts, one stops teach
// - bus or key start the same teach
// - key held five seconds starts teach
// - teach: bottom, valve on, travel, top, off, return
// - ignore bus valve commands while teaching
// - full valve power, reduced after 100 ms
// - status LED flashes while teaching
// - status LED flickers when puck is missing
// - valve LED lit while pilot energized
// - bus LEDs dark unpowered, green when ok
// - watchdog expired, address nonzero: red only
// - address zero: green flashes, red on
// - overload or external reset: red flashes
//
// Implementation choices: the placing of the registers and the APB slave port.
`default_nettype none

module valve_slave_io
  import valve_slave_pkg::*;
#(
  parameter int TICK_COUNT = TICK_CYCLES,
  parameter int KEY_HOLD_TICKS = KEY_HOLD_MS,
  parameter int POWER_FULL_TICKS = POWER_FULL_MS,
  parameter int WDOG_TICKS = WDOG_MS,
  parameter int TRAVEL_TICKS = TRAVEL_MS,
  parameter int FLASH_TICKS = FLASH_HALF_MS,
  parameter int FLICKER_TICKS = FLICKER_HALF_MS
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  // field bus link layer
  input wire logic link_power_ok,
  input wire logic link_valid,
  input wire logic [3:0] link_out_data,
  input wire logic link_param_valid,
  input wire logic [3:0] link_param,
  input wire logic [4:0] slave_addr,
  input wire logic sensor_overload,
  input wire logic ext_reset,
  output logic [3:0] in_data,
  // local inputs
  input wire logic teach_key,
  input wire logic puck_present,
  input wire logic [7:0] position,
  // valve and indicators
  output logic valve_output,
  output logic valve_full_power,
  output logic valve_led,
  output logic status_led,
  output logic bus_led_green,
  output logic bus_led_red
);

  typedef struct packed {
    logic [15:0] tick_cnt;
    logic tick;
    logic [15:0] flash_cnt;
    logic flash;
    logic [15:0] flicker_cnt;
    logic flicker;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [3:0] irq_stat;
    logic [3:0] irq_mask;
    logic irq;
    teach_state_t phase;
    logic [15:0] tcnt;
    logic [7:0] bot_pos;
    logic [7:0] top_pos;
    logic calibrated;
    logic bus_cmd;
    logic key_prev;
    logic wdog_prev;
    logic puck_prev;
    logic [3:0] in_data;
    logic valve_output;
    logic valve_full_power;
    logic valve_led;
    logic status_led;
    logic bus_led_green;
    logic bus_led_red;
  } state_t;

  state_t st;
  state_t next_st;

  logic key_expired;
  logic power_expired;
  logic wdog_expired;

  logic access;
  logic commit;
  logic sw_start;
  logic sw_stop;
  logic bus_start;
  logic bus_stop;
  logic key_start;
  logic teaching;
  logic teach_valve;
  logic valve_on;
  logic top_hit;
  logic bot_hit;
  logic [3:0] events;
  logic [3:0] w1c;

  function automatic logic within_tol(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] diff;
    diff = (a > b) ? 8'(a - b) : 8'(b - a);
    return diff <= POS_TOL;
  endfunction

  // ----------------------------------------
  // millisecond timers
  // ----------------------------------------
  valve_ms_timer #(.LIMIT_MS(KEY_HOLD_TICKS)) key_timer (
    .pclk(pclk),
    .presetn(presetn),
    .tick(st.tick),
    .clear(!teach_key),
    .expired(key_expired)
  );

  valve_ms_timer #(.LIMIT_MS(POWER_FULL_TICKS)) power_timer (
    .pclk(pclk),
    .presetn(presetn),
    .tick(st.tick),
    .clear(!st.valve_output),
    .expired(power_expired)
  );

  valve_ms_timer #(.LIMIT_MS(WDOG_TICKS)) wdog_timer (
    .pclk(pclk),
    .presetn(presetn),
    .tick(st.tick),
    .clear(link_valid),
    .expired(wdog_expired)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_st = st;
    access = psel && penable;
    commit = access && st.pready && pwrite;
    sw_start = 1'b0;
    sw_stop = 1'b0;
    w1c = 4'h0;
    events = 4'h0;

    // millisecond tick and blink rates
    next_st.tick = 1'b0;
    if (st.tick_cnt == 16'(TICK_COUNT - 1)) begin
      next_st.tick_cnt = 16'h0000;
      next_st.tick = 1'b1;
    end else begin
      next_st.tick_cnt = st.tick_cnt + 16'h0001;
    end
    if (st.tick) begin
      if (st.flash_cnt == 16'(FLASH_TICKS - 1)) begin
        next_st.flash_cnt = 16'h0000;
        next_st.flash = !st.flash;
      end else begin
        next_st.flash_cnt = st.flash_cnt + 16'h0001;
      end
      if (st.flicker_cnt == 16'(FLICKER_TICKS - 1)) begin
        next_st.flicker_cnt = 16'h0000;
        next_st.flicker = !st.flicker;
      end else begin
        next_st.flicker_cnt = st.flicker_cnt + 16'h0001;
      end
    end

    // apb: one wait state, read data and error prepared in it
    next_st.pready = access && !st.pready;
    if (access && !st.pready) begin
      next_st.pslverr = 1'b0;
      next_st.prdata = 32'h0000_0000;
      case (paddr)
        CTRL_OFS: begin
          next_st.prdata = 32'h0000_0000;
        end
        STATUS_OFS: begin
          next_st.prdata[ST_TEACHING_BIT] = st.phase != T_IDLE;
          next_st.prdata[ST_VALVE_BIT] = st.valve_output;
          next_st.prdata[ST_WDOG_BIT] = wdog_expired;
          next_st.prdata[ST_PUCK_BIT] = puck_present;
          next_st.prdata[ST_TOP_BIT] = st.in_data[TOP_REACHED_BIT];
          next_st.prdata[ST_BOT_BIT] = st.in_data[BOTTOM_REACHED_BIT];
          next_st.prdata[ST_CAL_BIT] = st.calibrated;
        end
        POSITION_OFS: begin
          next_st.prdata[15:0] = {st.top_pos, st.bot_pos};
        end
        IRQ_STATUS_OFS: begin
          next_st.prdata[3:0] = st.irq_stat;
        end
        IRQ_MASK_OFS: begin
          next_st.prdata[3:0] = st.irq_mask;
        end
        default: begin
          next_st.pslverr = 1'b1;
        end
      endcase
    end else if (!access) begin
      next_st.pslverr = 1'b0;
    end
    if (commit) begin
      case (paddr)
        CTRL_OFS: begin
          sw_start = pwdata[CTRL_START_BIT];
          sw_stop = pwdata[CTRL_STOP_BIT];
        end
        IRQ_STATUS_OFS: begin
          w1c = pwdata[3:0];
        end
        IRQ_MASK_OFS: begin
          next_st.irq_mask = pwdata[3:0];
        end
        default: begin
          w1c = 4'h0;
        end
      endcase
    end

    // teach requests from key and bus
    next_st.key_prev = key_expired;
    key_start = key_expired && !st.key_prev;
    bus_start = link_param_valid && !link_param[TEACH_CONTROL_PARAM];
    bus_stop = link_param_valid && link_param[TEACH_CONTROL_PARAM];
    if (link_valid) begin
      next_st.bus_cmd = link_out_data[PILOT_VALVE_CMD_BIT];
    end

    // teach sequence
    teaching = st.phase != T_IDLE;
    case (st.phase)
      T_IDLE: begin
        if ((sw_start || bus_start || key_start) && puck_present) begin
          next_st.phase = T_CAPT_BOT;
        end
      end
      T_CAPT_BOT: begin
        next_st.bot_pos = position;
        next_st.tcnt = 16'h0000;
        next_st.phase = T_RISE;
      end
      T_RISE: begin
        if (st.tick) begin
          next_st.tcnt = st.tcnt + 16'h0001;
        end
        if (st.tcnt == 16'(TRAVEL_TICKS)) begin
          next_st.phase = T_CAPT_TOP;
        end
      end
      T_CAPT_TOP: begin
        next_st.top_pos = position;
        next_st.tcnt = 16'h0000;
        next_st.phase = T_FALL;
      end
      T_FALL: begin
        if (st.tick) begin
          next_st.tcnt = st.tcnt + 16'h0001;
        end
        if (st.tcnt == 16'(TRAVEL_TICKS)) begin
          next_st.phase = T_IDLE;
          next_st.calibrated = 1'b1;
          events[IRQ_TEACH_DONE_BIT] = 1'b1;
        end
      end
      default: begin
        next_st.phase = T_IDLE;
      end
    endcase
    if (teaching && (sw_stop || bus_stop || !puck_present)) begin
      next_st.phase = T_IDLE;
    end

    // pilot valve drive
    teach_valve = (st.phase == T_RISE) || (st.phase == T_CAPT_TOP);
    if (next_st.phase == T_IDLE) begin
      valve_on = st.bus_cmd && !wdog_expired;
    end else begin
      valve_on = teach_valve;
    end
    next_st.valve_output = valve_on;
    next_st.valve_full_power = valve_on && !power_expired;
    next_st.valve_led = valve_on;

    // end position reporting
    top_hit = st.calibrated && puck_present && within_tol(position, st.top_pos);
    bot_hit = st.calibrated && puck_present && within_tol(position, st.bot_pos);
    next_st.in_data = 4'h0;
    next_st.in_data[TOP_REACHED_BIT] = top_hit;
    next_st.in_data[BOTTOM_REACHED_BIT] = bot_hit;

    // status LED
    if (!puck_present) begin
      next_st.status_led = st.flicker;
    end else if (teaching) begin
      next_st.status_led = st.flash;
    end else begin
      next_st.status_led = 1'b0;
    end

    // bus LEDs
    if (!link_power_ok) begin
      next_st.bus_led_green = 1'b0;
      next_st.bus_led_red = 1'b0;
    end else if (sensor_overload || ext_reset) begin
      next_st.bus_led_green = 1'b0;
      next_st.bus_led_red = st.flash;
    end else if (slave_addr == 5'h00) begin
      next_st.bus_led_green = st.flash;
      next_st.bus_led_red = 1'b1;
    end else if (wdog_expired) begin
      next_st.bus_led_green = 1'b0;
      next_st.bus_led_red = 1'b1;
    end else begin
      next_st.bus_led_green = 1'b1;
      next_st.bus_led_red = 1'b0;
    end

    // sticky interrupt events, set wins over clear
    next_st.wdog_prev = wdog_expired;
    next_st.puck_prev = puck_present;
    events[IRQ_WDOG_BIT] = wdog_expired && !st.wdog_prev;
    events[IRQ_PUCK_LOST_BIT] = st.puck_prev && !puck_present;
    events[IRQ_KEY_START_BIT] = key_start;
    next_st.irq_stat = (st.irq_stat & ~w1c) | events;
    next_st.irq = |(next_st.irq_stat & next_st.irq_mask);
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.phase <= T_IDLE;
      st.bot_pos <= POS_RESET;
      st.top_pos <= POS_RESET;
      st.irq_mask <= IRQ_MASK_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign irq = st.irq;
  assign in_data = st.in_data;
  assign valve_output = st.valve_output;
  assign valve_full_power = st.valve_full_power;
  assign valve_led = st.valve_led;
  assign status_led = st.status_led;
  assign bus_led_green = st.bus_led_green;
  assign bus_led_red = st.bus_led_red;

endmodule

`default_nettype wire

// ### pkg/valve_slave_pkg.sv
`default_nettype none

package valve_slave_pkg;

  // ----------------------------------------
  // clock and time base
  // ----------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

  // ----------------------------------------
  // timing in milliseconds
  // ----------------------------------------
  localparam int KEY_HOLD_MS = 5000;
  localparam int POWER_FULL_MS = 100;
  localparam int WDOG_MS = 50;
  localparam int TRAVEL_MS = 2000;
  localparam int FLASH_HALF_MS = 250;
  localparam int FLICKER_HALF_MS = 50;

  // ----------------------------------------
  // field bus data bits
  // ----------------------------------------
  localparam int TOP_REACHED_BIT = 3;
  localparam int BOTTOM_REACHED_BIT = 2;
  localparam int UNUSED_OUTPUT_BIT = 1;
  localparam int PILOT_VALVE_CMD_BIT = 0;
  localparam int TEACH_CONTROL_PARAM = 0;

  // ----------------------------------------
  // position sensing
  // ----------------------------------------
  localparam logic [7:0] POS_TOL = 8'h04;
  localparam logic [7:0] POS_RESET = 8'h00;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] POSITION_OFS = 8'h08;
  localparam logic [7:0] IRQ_STATUS_OFS = 8'h0c;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h10;

  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_STOP_BIT = 1;

  localparam int ST_TEACHING_BIT = 0;
  localparam int ST_VALVE_BIT = 1;
  localparam int ST_WDOG_BIT = 2;
  localparam int ST_PUCK_BIT = 3;
  localparam int ST_TOP_BIT = 4;
  localparam int ST_BOT_BIT = 5;
  localparam int ST_CAL_BIT = 6;

  localparam int IRQ_TEACH_DONE_BIT = 0;
  localparam int IRQ_WDOG_BIT = 1;
  localparam int IRQ_PUCK_LOST_BIT = 2;
  localparam int IRQ_KEY_START_BIT = 3;
  localparam logic [3:0] IRQ_MASK_RESET = 4'h0;

  // ----------------------------------------
  // teach sequence phases
  // ----------------------------------------
  typedef enum logic [2:0] {
    T_IDLE,
    T_CAPT_BOT,
    T_RISE,
    T_CAPT_TOP,
    T_FALL
  } teach_state_t;

endpackage

`default_nettype wire

// ### verif/fieldbus_master_model.sv
`default_nettype none
module fieldbus_master_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // bench control
  input wire logic valve_cmd,
  input wire logic poll_en,
  input wire logic param_go,
  input wire logic param_bit,
  // slave link
  input wire logic [3:0] in_data,
  output logic link_valid,
  output logic [3:0] link_out_data,
  output logic link_param_valid,
  output logic [3:0] link_param,
  output logic [3:0] polled
);
  timeunit 1ns;
  timeprecision 1ps;
  int gap;
  logic spare;
  // polls every ten cycles, lines churn between frames
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap <= 0;
      spare <= 1'b0;
      link_valid <= 1'b0;
      link_out_data <= 4'h0;
      link_param_valid <= 1'b0;
      link_param <= 4'h0;
      polled <= 4'h0;
    end else begin
      gap <= gap == 9 ? 0 : gap + 1;
      link_valid <= poll_en && gap == 9;
      if (poll_en && gap == 9) begin
        spare <= ~spare;
        link_out_data <= {2'b00, spare, valve_cmd};
      end else begin
        link_out_data <= ~link_out_data;
      end
      if (link_valid) polled <= in_data;
      link_param_valid <= param_go;
      link_param <= param_go ? {3'b111, param_bit} : ~link_param;
    end
  end
endmodule
`default_nettype wire

// ### verif/valve_slave_io_monitor.sv
`default_nettype none
module valve_slave_io_monitor #(
  parameter int TICK_COUNT = 4,
  parameter int POWER_FULL_TICKS = 5,
  parameter int WDOG_TICKS = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // link side
  input wire logic link_power_ok,
  input wire logic link_valid,
  input wire logic [4:0] slave_addr,
  input wire logic sensor_overload,
  input wire logic ext_reset,
  input wire logic puck_present,
  // outputs
  input wire logic [3:0] in_data,
  input wire logic valve_output,
  input wire logic valve_full_power,
  input wire logic valve_led,
  input wire logic bus_led_green,
  input wire logic bus_led_red
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PF_MAX = (POWER_FULL_TICKS + 1) * TICK_COUNT + 2;
  localparam int PF_MIN = (POWER_FULL_TICKS - 1) * TICK_COUNT - 1;
  localparam int WD_LIM = (WDOG_TICKS + 1) * TICK_COUNT + 2;
  localparam int WD_OK = (WDOG_TICKS - 1) * TICK_COUNT - 2;
  int pf_cnt;
  int wd_cnt;
  // ----
  // cycle counters
  // ----
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pf_cnt <= 0;
      wd_cnt <= 0;
    end else begin
      pf_cnt <= valve_full_power ? pf_cnt + 1 : 0;
      wd_cnt <= link_valid ? 0 : (wd_cnt < 999 ? wd_cnt + 1 : wd_cnt);
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_valve_on;
    !valve_output ##1 valve_output;
  endsequence
  sequence s_bus_clean;
    link_power_ok && !sensor_overload && !ext_reset && slave_addr != 5'h00;
  endsequence
  // ----
  // properties
  // ----
  a_valve_led_match: assert property (valve_led == valve_output)
    else $error("valve led differs from valve");
  a_full_at_start: assert property (s_valve_on |-> valve_full_power)
    else $error("valve on without full power");
  a_full_too_long: assert property (pf_cnt <= PF_MAX)
    else $error("full power held too long");
  a_full_too_short: assert property (
    valve_output && $fell(valve_full_power) |-> pf_cnt >= PF_MIN)
    else $error("full power dropped too early");
  a_bus_dark: assert property (
    !link_power_ok |=> !bus_led_green && !bus_led_red)
    else $error("bus leds lit while unpowered");
  a_bus_green_ok: assert property (
    s_bus_clean ##0 (wd_cnt > 2 && wd_cnt < WD_OK) |=> bus_led_green && !bus_led_red)
    else $error("bus leds not ok state");
  a_wdog_red_on: assert property (
    s_bus_clean ##0 wd_cnt > WD_LIM |=> bus_led_red && !bus_led_green)
    else $error("no red after watchdog expiry");
  a_addr_zero_red: assert property (
    link_power_ok && !sensor_overload && !ext_reset && slave_addr == 5'h00 |=> bus_led_red)
    else $error("red off at address zero");
  a_fault_green_off: assert property (
    link_power_ok && (sensor_overload || ext_reset) |=> !bus_led_green)
    else $error("green on during fault");
  a_wdog_valve_off: assert property (wd_cnt > WD_LIM |=> !valve_output)
    else $error("valve on after watchdog expiry");
  a_no_puck_flags: assert property (!puck_present [*2] |=> in_data == 4'h0)
    else $error("reached flags without puck");
endmodule
bind valve_slave_io valve_slave_io_monitor #(.TICK_COUNT(TICK_COUNT),
  .POWER_FULL_TICKS(POWER_FULL_TICKS), .WDOG_TICKS(WDOG_TICKS)) u_valve_slave_io_monitor (
  .pclk(pclk), .presetn(presetn),
  .link_power_ok(link_power_ok), .link_valid(link_valid), .slave_addr(slave_addr),
  .sensor_overload(sensor_overload), .ext_reset(ext_reset), .puck_present(puck_present),
  .in_data(in_data), .valve_output(valve_output), .valve_full_power(valve_full_power),
  .valve_led(valve_led), .bus_led_green(bus_led_green), .bus_led_red(bus_led_red)
);
`default_nettype wire

// ### verif/valve_slave_io_tb.sv
`default_nettype none
module valve_slave_io_tb;
  import valve_slave_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
  logic [7:0] paddr = 0, position = 8'h10;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, irq, link_valid, link_param_valid, valve_output, valve_full_power;
  logic link_power_ok = 1, sensor_overload = 0, ext_reset = 0, teach_key = 0;
  logic puck_present = 1, valve_cmd = 0, poll_en = 1, param_go = 0, param_bit = 1;
  logic valve_led, status_led, bus_led_green, bus_led_red;
  logic [3:0] link_out_data, link_param, in_data, polled;
  logic [4:0] slave_addr = 5'h05;
  logic [2:0] lp = 0;
  wire [2:0] leds = {bus_led_red, bus_led_green, status_led};
  int tg[3];
  int fail_count = 0;
  int check_count = 0;
  valve_slave_io #(.TICK_COUNT(4), .KEY_HOLD_TICKS(10), .POWER_FULL_TICKS(5), .WDOG_TICKS(8),
    .TRAVEL_TICKS(6), .FLASH_TICKS(3), .FLICKER_TICKS(2)) u_valve_slave_io (
    .pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .link_power_ok(link_power_ok), .link_valid(link_valid), .link_out_data(link_out_data),
    .link_param_valid(link_param_valid), .link_param(link_param), .slave_addr(slave_addr),
    .sensor_overload(sensor_overload), .ext_reset(ext_reset), .in_data(in_data),
    .teach_key(teach_key), .puck_present(puck_present), .position(position),
    .valve_output(valve_output), .valve_full_power(valve_full_power), .valve_led(valve_led),
    .status_led(status_led), .bus_led_green(bus_led_green), .bus_led_red(bus_led_red)
  );
  fieldbus_master_model u_fieldbus_master_model (
    .pclk(pclk), .presetn(presetn),
    .valve_cmd(valve_cmd), .poll_en(poll_en), .param_go(param_go), .param_bit(param_bit),
    .in_data(in_data), .link_valid(link_valid), .link_out_data(link_out_data),
    .link_param_valid(link_param_valid), .link_param(link_param), .polled(polled)
  );
  initial begin
    forever #12.5 pclk = ~pclk;
  end
  // ----
  // led toggle counts
  // ----
  always @(posedge pclk) begin
    for (int i = 0; i < 3; i++)
      if (lp[i] !== leds[i]) tg[i]++;
    lp <= leds;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic win(input int n);
    cyc(3);
    @(negedge pclk);
    tg = '{0, 0, 0};
    cyc(n);
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    repeat (20) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    chk(pready, 1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    cyc(2);
  endtask
  task automatic prm(input logic b);
    param_bit <= b;
    param_go <= 1;
    cyc(1);
    param_go <= 0;
    cyc(6);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    cyc(5000);
    fail_count++;
    finish_test;
  end
  initial begin
    cyc(12);
    presetn <= 1;
    cyc(2);
    apb(0, IRQ_MASK_OFS, 0);
    chk(rd, 0);
    apb(0, 8'h14, 0);
    chk(rd, 32'h0);
    chk(er, 1);
    valve_cmd <= 1;
    cyc(14);
    chk({valve_output, valve_full_power, valve_led}, 3'b111);
    cyc(30);
    chk({valve_output, valve_full_power, valve_led}, 3'b101);
    poll_en <= 0;
    cyc(60);
    chk({valve_output, bus_led_green, bus_led_red}, 3'b001);
    apb(0, IRQ_STATUS_OFS, 0);
    chk({rd[IRQ_WDOG_BIT], irq}, 2'b10);
    apb(1, IRQ_MASK_OFS, 32'h2);
    chk(irq, 1);
    poll_en <= 1;
    apb(1, IRQ_STATUS_OFS, 32'h2);
    chk(irq, 0);
    valve_cmd <= 0;
    cyc(15);
    prm(0);
    chk(valve_output, 1);
    position <= 8'h80;
    win(60);
    chk(tg[0] >= 3, 1);
    apb(0, POSITION_OFS, 0);
    chk(rd, 32'h8010);
    apb(0, STATUS_OFS, 0);
    chk({rd[ST_CAL_BIT], rd[ST_TEACHING_BIT], valve_output}, 3'b100);
    cyc(12);
    chk(polled, 4'h8);
    position <= 8'h12;
    cyc(25);
    chk(polled, 4'h4);
    teach_key <= 1;
    cyc(20);
    teach_key <= 0;
    apb(0, STATUS_OFS, 0);
    chk(rd[ST_TEACHING_BIT], 0);
    teach_key <= 1;
    cyc(50);
    teach_key <= 0;
    apb(0, STATUS_OFS, 0);
    chk(rd[ST_TEACHING_BIT], 1);
    apb(0, IRQ_STATUS_OFS, 0);
    chk({rd[IRQ_KEY_START_BIT], rd[IRQ_TEACH_DONE_BIT]}, 2'b11);
    prm(1);
    apb(0, STATUS_OFS, 0);
    chk(rd[ST_TEACHING_BIT], 0);
    apb(1, CTRL_OFS, 32'h1);
    apb(0, STATUS_OFS, 0);
    chk(rd[ST_TEACHING_BIT], 1);
    apb(1, CTRL_OFS, 32'h2);
    apb(0, STATUS_OFS, 0);
    chk({rd[ST_TEACHING_BIT], valve_output}, 2'b00);
    puck_present <= 0;
    win(40);
    chk(tg[0] >= 3, 1);
    chk(in_data, 0);
    apb(0, IRQ_STATUS_OFS, 0);
    chk(rd[IRQ_PUCK_LOST_BIT], 1);
    puck_present <= 1;
    slave_addr <= 0;
    win(40);
    chk({tg[1] != 0, tg[2] != 0, bus_led_red}, 3'b101);
    slave_addr <= 5'h05;
    for (int i = 1; i < 3; i++) begin
      ext_reset <= i[1];
      sensor_overload <= i[0];
      win(40);
      chk({tg[1] != 0, tg[2] != 0, bus_led_green}, 3'b010);
    end
    ext_reset <= 1'b0;
    sensor_overload <= 1'b0;
    link_power_ok <= 0;
    cyc(3);
    chk({bus_led_green, bus_led_red}, 2'b00);
    link_power_ok <= 1;
    cyc(3);
    chk({bus_led_green, bus_led_red}, 2'b10);
    finish_test;
  end
endmodule
`default_nettype wire
